// >>> design/ssx_defines.vh
// Shared constants of the clocked synchronous serial unit
`ifndef SSX_DEFINES_VH
`define SSX_DEFINES_VH

// ==========================================================
// Character format
// ==========================================================
`define SSX_CHAR_BITS 8
`define SSX_LAST_BIT 3'h7
`define SSX_CNT_W 3

// ==========================================================
// Flag positions on the status read, clear and arm vectors
// ==========================================================
`define SSX_FLAG_W 6
`define SSX_F_TX_DONE 0
`define SSX_F_PARITY 1
`define SSX_F_FRAMING 2
`define SSX_F_OVERRUN 3
`define SSX_F_RX_FULL 4
`define SSX_F_TX_EMPTY 5

// ==========================================================
// Reset values
// ==========================================================
`define SSX_RST_TX_EMPTY 1'h1
`define SSX_RST_TX_DONE 1'h1
`define SSX_RST_FLAG 1'h0
`define SSX_RST_DATA 8'h00
`define SSX_RST_SCK 1'h1
`define SSX_RST_TXD 1'h1
`define SSX_RST_LINE 1'h1

// ==========================================================
// Divider
// ==========================================================
`define SSX_DIV_W 8
`define SSX_RST_DIV 8'h00

`endif

// >>> design/ssx_pin_sync.v
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module ssx_pin_sync #(
  parameter RESET_LEVEL = 1'b1
) (
  input wire clk,
  input wire reset,
  input wire pin_in,
  output reg level_q,
  output reg rise_q,
  output reg fall_q
);

  reg stage1_q;
  reg stage2_q;
  reg stage3_q;

  // ==========================================================
  // Synchroniser chain
  // ==========================================================
  // First stage feeds only the second one
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1_q <= RESET_LEVEL;
      stage2_q <= RESET_LEVEL;
      stage3_q <= RESET_LEVEL;
    end else begin
      stage1_q <= pin_in;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // A change counts once stages two and three agree
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      level_q <= RESET_LEVEL;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if ((stage2_q == stage3_q) && (stage2_q != level_q)) begin
        level_q <= stage2_q;
        rise_q <= stage2_q;
        fall_q <= ~stage2_q;
      end
    end
  end

endmodule // ssx_pin_sync

// >>> design/ssx_rate_gen.v
// Bit rate divider giving one enable pulse per serial half period
`timescale 1ns/10ps
`include "ssx_defines.vh"
module ssx_rate_gen #(
  parameter DIV_W = `SSX_DIV_W
) (
  input wire clk,
  input wire reset,
  input wire run,
  input wire [DIV_W-1:0] divisor,
  output reg tick_q
);

  reg [DIV_W-1:0] count_q;

  // ==========================================================
  // Divider
  // ==========================================================
  // Pulse every divisor+1 cycles; held at zero while stopped so
  // the first half period after a start is always full length
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q <= {DIV_W{1'b0}};
      tick_q <= 1'b0;
    end else if (!run) begin
      count_q <= {DIV_W{1'b0}};
      tick_q <= 1'b0;
    end else if (count_q >= divisor) begin
      count_q <= {DIV_W{1'b0}};
      tick_q <= 1'b1;
    end else begin
      count_q <= count_q + {{(DIV_W-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end

endmodule // ssx_rate_gen

// >>> design/ssx_sync_serial.v
// Clocked synchronous transmitter and receiver of the serial unit
`timescale 1ns/10ps
`include "ssx_defines.vh"

// Notes on behaviour
// - One shared clock, independent double-buffered directions
// - Drive each bit falling edge to falling
// - LSB first; line holds last bit after
// - Exactly eight data bits, no extras
// - Clock source picked by mode, select bits
// - Internal clock: eight pulses, idle high
// - External clock: shift on incoming edges
// - Empty cleared: load shifter, set empty
// - At bit 7 chain or end
// - Tx disable resets; rx disable keeps flags
// - Pins used only with selection and enable; external sck input ignores sck_pin_sel
// - Parity/framing flag blocks all transfers
// - Receiver synchronises and resets at start
// - Eight bits to holding if full clear
// - Error flag set: no new full flag
// - Full and overrun raise receive interrupts
// - DMA accesses clear empty and full flags
// - Overrun when full; holding keeps old data
// - No transmit start while error set
// - Only empty and full requests start DMA
module ssx_sync_serial #(
  parameter DIV_W = `SSX_DIV_W
) (
  input wire clk,
  input wire reset,
  // Configuration
  input wire sync_mode,
  input wire clk_src_sel_hi,
  input wire clk_src_sel_lo,
  input wire [DIV_W-1:0] bit_rate_divisor,
  input wire tx_enable,
  input wire rx_enable,
  input wire tx_empty_irq_en,
  input wire rx_irq_en,
  input wire tx_done_irq_en,
  input wire tx_pin_sel,
  input wire rx_pin_sel,
  input wire sck_pin_sel,
  // Software and DMA access
  input wire tx_wr,
  input wire dma_tx_wr,
  input wire [7:0] tx_wdata,
  input wire dma_rx_rd,
  input wire flag_rd,
  input wire flag_wr,
  input wire [`SSX_FLAG_W-1:0] flag_wdata,
  input wire parity_err_set,
  input wire framing_err_set,
  // Status
  output reg [7:0] rx_holding_reg,
  output reg tx_empty_flag,
  output reg tx_done_flag,
  output reg rx_full_flag,
  output reg overrun_flag,
  output reg framing_flag,
  output reg parity_flag,
  output reg tx_empty_irq,
  output reg rx_full_irq,
  output reg rx_error_irq,
  output reg tx_done_irq,
  output reg dma_tx_req,
  output reg dma_rx_req,
  // Pins
  input wire sck_i,
  output reg sck_o,
  output reg sck_oe,
  input wire rxd_i,
  output reg txd_o,
  output reg txd_oe
);

  // ==========================================================
  // Declarations
  // ==========================================================
  reg [7:0] tx_holding_reg, tx_shifter;
  reg [`SSX_CNT_W-1:0] tx_cnt_q;
  reg tx_busy_q, tx_last_q;
  reg [7:0] rx_shifter;
  reg [`SSX_CNT_W-1:0] rx_cnt_q, pulse_cnt_q;
  reg [`SSX_FLAG_W-1:0] armed_q;
  wire [`SSX_FLAG_W-1:0] flags, sw_clear;
  wire sck_level, sck_rise, sck_fall, rxd_level, tick;
  wire use_int, use_ext, err_any, tx_active, rx_active;
  wire rx_solo_want, gen_want, fall_ev, rise_ev;
  wire tx_start, tx_chain, tx_end, rx_done;

  // ==========================================================
  // Clock source and gating
  // ==========================================================
  // Sync mode with high select clear means internal clock
  // clock source select
  assign use_int = sync_mode & ~clk_src_sel_hi;
  assign use_ext = sync_mode & clk_src_sel_hi;
  // Low select bit only matters in the asynchronous mode
  // errors block both
  assign err_any = overrun_flag | framing_flag | parity_flag;
  assign tx_active = sync_mode & tx_enable & tx_pin_sel;
  assign rx_active = sync_mode & rx_enable & rx_pin_sel & ~err_any;
  // Receive-only runs the clock only while a character can land
  assign rx_solo_want = rx_active & ~tx_active & ~rx_full_flag;
  assign gen_want = (pulse_cnt_q != 3'h0) | tx_busy_q | rx_solo_want;

  ssx_pin_sync #(
    .RESET_LEVEL(`SSX_RST_LINE)
  ) u_sck_sync (
    .clk(clk),
    .reset(reset),
    .pin_in(sck_i),
    .level_q(sck_level),
    .rise_q(sck_rise),
    .fall_q(sck_fall)
  );

  ssx_pin_sync #(
    .RESET_LEVEL(`SSX_RST_LINE)
  ) u_rxd_sync (
    .clk(clk),
    .reset(reset),
    .pin_in(rxd_i),
    .level_q(rxd_level),
    .rise_q(),
    .fall_q()
  );

  ssx_rate_gen #(
    .DIV_W(DIV_W)
  ) u_rate (
    .clk(clk),
    .reset(reset),
    .run(use_int),
    .divisor(bit_rate_divisor),
    .tick_q(tick)
  );

  assign fall_ev = use_int ? (tick & sck_o & gen_want) : (use_ext & sck_fall);
  assign rise_ev = use_int ? (tick & ~sck_o) : (use_ext & sck_rise);

  // ==========================================================
  // Internal serial clock generator
  // ==========================================================
  // eight pulses then high
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sck_o <= `SSX_RST_SCK;
      pulse_cnt_q <= 3'h0;
    end else if (!use_int) begin
      sck_o <= `SSX_RST_SCK;
      pulse_cnt_q <= 3'h0;
    end else if (fall_ev) begin
      sck_o <= 1'b0;
    end else if (rise_ev) begin
      sck_o <= 1'b1;
      pulse_cnt_q <= pulse_cnt_q + 3'h1;
    end
  end

  // ==========================================================
  // Transmitter
  // ==========================================================
  // load when empty clears
  assign tx_start = tx_active & ~tx_busy_q & ~tx_empty_flag & ~err_any;
  assign tx_chain = fall_ev & tx_busy_q & (tx_cnt_q == `SSX_LAST_BIT) &
                    ~tx_empty_flag & ~err_any;
  assign tx_end = fall_ev & tx_busy_q & (tx_cnt_q == `SSX_LAST_BIT) & ~tx_chain;

  // Holding register; a write while not empty overwrites old data
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_holding_reg <= `SSX_RST_DATA;
    end else if (tx_wr | dma_tx_wr) begin
      tx_holding_reg <= tx_wdata;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_shifter <= `SSX_RST_DATA;
      tx_cnt_q <= 3'h0;
      tx_busy_q <= 1'b0;
      tx_last_q <= 1'b0;
      txd_o <= `SSX_RST_TXD;
    end else if (!tx_active) begin
      tx_shifter <= `SSX_RST_DATA;
      tx_cnt_q <= 3'h0;
      tx_busy_q <= 1'b0;
      tx_last_q <= 1'b0;
    end else if (tx_start) begin
      tx_shifter <= tx_holding_reg;
      tx_cnt_q <= 3'h0;
      tx_busy_q <= 1'b1;
      tx_last_q <= 1'b0;
    end else begin
      if (fall_ev && tx_busy_q && !tx_last_q) begin
        txd_o <= tx_shifter[tx_cnt_q];
        tx_cnt_q <= tx_cnt_q + 3'h1;
        if (tx_chain) begin
          tx_shifter <= tx_holding_reg;
        end
        if (tx_end) begin
          tx_last_q <= 1'b1;
        end
      end
      if (rise_ev && tx_last_q) begin
        tx_busy_q <= 1'b0;
        tx_last_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Receiver
  // ==========================================================
  // eight bits per character
  assign rx_done = rise_ev & rx_active & (rx_cnt_q == `SSX_LAST_BIT);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_shifter <= `SSX_RST_DATA;
      rx_cnt_q <= 3'h0;
    end else if (!rx_active) begin
      rx_cnt_q <= 3'h0;
    end else if (rise_ev) begin
      rx_shifter <= {rxd_level, rx_shifter[7:1]};
      rx_cnt_q <= rx_cnt_q + 3'h1;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_holding_reg <= `SSX_RST_DATA;
    end else if (rx_done && !rx_full_flag) begin
      rx_holding_reg <= {rxd_level, rx_shifter[7:1]};
    end
  end

  // ==========================================================
  // Flags
  // ==========================================================
  assign flags[`SSX_F_TX_DONE] = tx_done_flag;
  assign flags[`SSX_F_PARITY] = parity_flag;
  assign flags[`SSX_F_FRAMING] = framing_flag;
  assign flags[`SSX_F_OVERRUN] = overrun_flag;
  assign flags[`SSX_F_RX_FULL] = rx_full_flag;
  assign flags[`SSX_F_TX_EMPTY] = tx_empty_flag;

  assign sw_clear = {`SSX_FLAG_W{flag_wr}} & ~flag_wdata & armed_q;

  // Reading a flag as one arms its clear; any write disarms
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      armed_q <= {`SSX_FLAG_W{1'b0}};
    end else if (flag_wr) begin
      armed_q <= {`SSX_FLAG_W{1'b0}};
    end else if (flag_rd) begin
      armed_q <= armed_q | flags;
    end
  end

  // Set always wins over a clear arriving in the same cycle
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_empty_flag <= `SSX_RST_TX_EMPTY;
      tx_done_flag <= `SSX_RST_TX_DONE;
      rx_full_flag <= `SSX_RST_FLAG;
      overrun_flag <= `SSX_RST_FLAG;
      framing_flag <= `SSX_RST_FLAG;
      parity_flag <= `SSX_RST_FLAG;
    end else begin
      if (tx_start || tx_chain || !tx_active) begin
        tx_empty_flag <= 1'b1;
      end else if (sw_clear[`SSX_F_TX_EMPTY] || dma_tx_wr) begin
        tx_empty_flag <= 1'b0;
      end
      if (tx_end) begin
        tx_done_flag <= 1'b1;
      end else if (sw_clear[`SSX_F_TX_DONE] || tx_start) begin
        tx_done_flag <= 1'b0;
      end
      if (rx_done && !rx_full_flag) begin
        rx_full_flag <= 1'b1;
      end else if (sw_clear[`SSX_F_RX_FULL] || dma_rx_rd) begin
        rx_full_flag <= 1'b0;
      end
      if (rx_done && rx_full_flag) begin
        overrun_flag <= 1'b1;
      end else if (sw_clear[`SSX_F_OVERRUN]) begin
        overrun_flag <= 1'b0;
      end
      if (framing_err_set) begin
        framing_flag <= 1'b1;
      end else if (sw_clear[`SSX_F_FRAMING]) begin
        framing_flag <= 1'b0;
      end
      if (parity_err_set) begin
        parity_flag <= 1'b1;
      end else if (sw_clear[`SSX_F_PARITY]) begin
        parity_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Requests and pin enables
  // ==========================================================
  // Registered one cycle behind the flags so all outputs are flops
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_empty_irq <= 1'b0;
      rx_full_irq <= 1'b0;
      rx_error_irq <= 1'b0;
      tx_done_irq <= 1'b0;
      dma_tx_req <= 1'b0;
      dma_rx_req <= 1'b0;
      txd_oe <= 1'b0;
      sck_oe <= 1'b0;
    end else begin
      rx_full_irq <= rx_irq_en & rx_full_flag;
      rx_error_irq <= rx_irq_en & err_any;
      tx_empty_irq <= tx_empty_irq_en & tx_empty_flag & tx_active;
      tx_done_irq <= tx_done_irq_en & tx_done_flag & tx_active;
      dma_tx_req <= tx_empty_flag & tx_active;
      dma_rx_req <= rx_full_flag & rx_enable;
      txd_oe <= tx_active;
      sck_oe <= use_int & sck_pin_sel & (tx_enable | rx_enable);
    end
  end

endmodule // ssx_sync_serial

// >>> design/ssx_rate_gen_fix.v
// Holds no logic; the bit rate divider lives in ssx_rate_gen.v

// >>> dv/ssx_sync_serial_props.sv
// Port-level assertions of the synchronous serial unit
`timescale 1ns/10ps
`include "ssx_defines.vh"
module ssx_sync_serial_props #(
  parameter DIV_W = `SSX_DIV_W
) (
  input wire clk,
  input wire reset,
  input wire sync_mode,
  input wire tx_enable,
  input wire rx_enable,
  input wire rx_irq_en,
  input wire tx_pin_sel,
  input wire dma_tx_wr,
  input wire dma_rx_rd,
  input wire flag_wr,
  input wire [`SSX_FLAG_W-1:0] flag_wdata,
  input wire parity_err_set,
  input wire [7:0] rx_holding_reg,
  input wire tx_empty_flag,
  input wire tx_done_flag,
  input wire rx_full_flag,
  input wire overrun_flag,
  input wire framing_flag,
  input wire parity_flag,
  input wire rx_full_irq,
  input wire rx_error_irq,
  input wire dma_rx_req,
  input wire sck_o,
  input wire sck_oe,
  input wire txd_o,
  input wire txd_oe
);
  // Any receive error stalls both directions
  wire err = overrun_flag | framing_flag | parity_flag;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================
  // Assertions
  a_txd_pin_use: assert property (txd_oe == $past(sync_mode & tx_enable & tx_pin_sel))
    else $error("txd enable wrong");
  a_full_irq_req: assert property (rx_full_irq == $past(rx_irq_en & rx_full_flag))
    else $error("full irq wrong");
  a_err_irq_req: assert property (rx_error_irq == $past(rx_irq_en & err))
    else $error("error irq wrong");
  a_dma_rx_req: assert property (dma_rx_req == $past(rx_full_flag & rx_enable))
    else $error("dma rx request wrong");
  a_dma_tx_clear: assert property (dma_tx_wr && tx_empty_flag && sync_mode && tx_enable
    && tx_pin_sel |=> !tx_empty_flag) else $error("dma write kept empty");
  a_dma_rx_clear: assert property (dma_rx_rd && rx_full_flag |=> !rx_full_flag)
    else $error("dma read kept full");
  a_write_one_kept: assert property (flag_wr && flag_wdata[`SSX_F_PARITY]
    && !parity_err_set |=> parity_flag == $past(parity_flag))
    else $error("write of one changed flag");
  a_bit_stable_high: assert property (sck_oe && sck_o && tx_enable && $past(tx_enable)
    |-> $stable(txd_o)) else $error("data moved while clock high");
  a_clock_only_out: assert property ($fell(sck_o) |-> sck_oe)
    else $error("clock pulse without output enable");
  a_no_start_err: assert property (err && !tx_empty_flag && tx_enable && tx_pin_sel
    && sync_mode ##1 tx_enable && tx_pin_sel |-> !tx_empty_flag)
    else $error("transmit started with error");
  a_overrun_keeps: assert property ($rose(overrun_flag) |-> $stable(rx_holding_reg))
    else $error("holding changed on overrun");
  a_full_not_err: assert property ($rose(rx_full_flag) |-> !$past(err))
    else $error("full set while error");
  a_load_clr_done: assert property ($rose(tx_empty_flag) && tx_enable && $past(tx_enable)
    |-> !tx_done_flag) else $error("load kept transmit end");
  // Main scenarios reached
  c_overrun: cover property ($rose(overrun_flag));
  c_tx_end: cover property ($rose(tx_done_flag));
  c_dma_wr: cover property (dma_tx_wr);
  c_full: cover property ($rose(rx_full_flag));
endmodule // ssx_sync_serial_props

bind ssx_sync_serial ssx_sync_serial_props #(.DIV_W(DIV_W)) props_u (.clk, .reset,
  .sync_mode, .tx_enable, .rx_enable, .rx_irq_en, .tx_pin_sel, .dma_tx_wr, .dma_rx_rd,
  .flag_wr, .flag_wdata, .parity_err_set, .rx_holding_reg, .tx_empty_flag, .tx_done_flag,
  .rx_full_flag, .overrun_flag, .framing_flag, .parity_flag, .rx_full_irq, .rx_error_irq,
  .dma_rx_req, .sck_o, .sck_oe, .txd_o, .txd_oe);

// >>> dv/ssx_peer.sv
// Behavioural synchronous serial peer on the pin side
`timescale 1ns/10ps
module ssx_peer (
  input wire clk,
  input wire sck_o,
  input wire sck_oe,
  input wire txd_o,
  input wire ext_go,
  input wire [7:0] send_base,
  output logic sck_i,
  output logic rxd_i,
  output int got,
  output int rises
);
  logic [7:0] rx_log [0:7];
  logic [7:0] sh;
  logic prev;
  int nb;
  int half;
  wire line = sck_oe ? sck_o : sck_i;
  wire [7:0] pb = send_base + got[7:0];
  initial begin
    sck_i = 1'b1;
    rxd_i = 1'b1;
    got = 0;
    rises = 0;
    nb = 0;
    prev = 1'b1;
    half = 0;
  end
  // external clock: two frames, 8-cycle halves, still between
  always @(posedge clk) begin
    if (ext_go && half == 0)
      half <= 256;
    else if (half > 0) begin
      half <= half - 1;
      if (half % 8 == 1) sck_i <= ~sck_i;
    end
  end
  // drive on fall, sample on rise, LSB first, 8 bits
  always @(posedge clk) begin
    prev <= line;
    if (prev && !line)
      rxd_i <= pb[nb];
    if (!prev && line) begin
      rises <= rises + 1;
      sh <= {txd_o, sh[7:1]};
      nb <= (nb + 1) % 8;
      if (nb == 7) begin
        rx_log[got] <= {txd_o, sh[7:1]};
        got <= got + 1;
        rxd_i <= ~rxd_i; // Hold no stale level between frames
      end
    end
  end
endmodule // ssx_peer

// >>> dv/ssx_sync_serial_test.sv
// Self-checking bench of the synchronous serial unit
`timescale 1ns/10ps
`define CHK(a, b, m) tests_run++; \
  if ((a) !== (b)) begin n_mismatch++; $display("Error at %0t: %s", $time, m); end
module ssx_sync_serial_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sync_mode = 1'b1;
  logic clk_src_sel_hi = 1'b0;
  logic [7:0] bit_rate_divisor = 8'h07;
  logic tx_enable = 1'b0;
  logic rx_enable = 1'b0;
  logic en_all = 1'b0;
  logic flag_rd = 1'b0, tx_wr = 1'b0, flag_wr = 1'b0, dma_tx_wr = 1'b0, dma_rx_rd = 1'b0;
  logic [7:0] tx_wdata = 8'h00;
  logic [5:0] flag_wdata = 6'h3f;
  logic parity_err_set = 1'b0, framing_err_set = 1'b0;
  logic ext_go = 1'b0;
  logic [7:0] base = 8'h00, b1, b2;
  integer seed = 23867;
  int n_mismatch = 0;
  int tests_run = 0;
  int got, rises;
  wire [7:0] rx_holding_reg;
  wire tx_empty_flag, tx_done_flag, rx_full_flag, overrun_flag, framing_flag, parity_flag;
  wire tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq, dma_tx_req, dma_rx_req;
  wire sck_i, sck_o, sck_oe, rxd_i, txd_o, txd_oe;
  always #4 clk = ~clk;
  ssx_sync_serial dut_u (.clk, .reset, .sync_mode, .clk_src_sel_hi, .clk_src_sel_lo(1'b0),
    .bit_rate_divisor, .tx_enable, .rx_enable, .tx_empty_irq_en(en_all), .rx_irq_en(en_all),
    .tx_done_irq_en(en_all), .tx_pin_sel(en_all), .rx_pin_sel(en_all), .sck_pin_sel(en_all),
    .tx_wr, .dma_tx_wr, .tx_wdata, .dma_rx_rd, .flag_rd, .flag_wr, .flag_wdata,
    .parity_err_set, .framing_err_set, .rx_holding_reg, .tx_empty_flag, .tx_done_flag,
    .rx_full_flag, .overrun_flag, .framing_flag, .parity_flag, .tx_empty_irq, .rx_full_irq,
    .rx_error_irq, .tx_done_irq, .dma_tx_req, .dma_rx_req, .sck_i, .sck_o, .sck_oe, .rxd_i,
    .txd_o, .txd_oe);
  ssx_peer peer_u (.clk, .sck_o, .sck_oe, .txd_o, .ext_go, .send_base(base), .sck_i, .rxd_i,
    .got, .rises);
  // ==========================================
  // Tasks
  // Peer sends its base plus the frame number
  function automatic [7:0] exp_rx(input [7:0] b, input int n);
    exp_rx = b + n[7:0];
  endfunction
  // One-cycle access pulse: read, write, flag write, dma write, dma read
  task op(input [4:0] p, input [7:0] d, input [5:0] w);
    @(negedge clk);
    {flag_rd, tx_wr, flag_wr, dma_tx_wr, dma_rx_rd} = p;
    tx_wdata = d;
    flag_wdata = w;
    @(negedge clk);
    {flag_rd, tx_wr, flag_wr, dma_tx_wr, dma_rx_rd} = 5'h00;
  endtask
  // read then write zero to clear
  task clr(input [5:0] w);
    op(5'h10, 8'h00, 6'h3f);
    op(5'h04, 8'h00, w);
  endtask
  // check empty, write, then clear empty
  task send_sw(input [7:0] b);
    op(5'h10, 8'h00, 6'h3f);
    op(5'h08, b, 6'h3f);
    op(5'h04, 8'h00, 6'h1f);
  endtask
  task wait_got(input int n);
    for (int i = 0; i < 5000 && got < n; i++)
      @(negedge clk);
    if (got < n) begin
      n_mismatch++;
      $display("Error at %0t: peer frame timeout", $time);
      end_sim;
    end else begin
      repeat (8) @(negedge clk);
    end
  endtask
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    base = $random(seed);
    b1 = $random(seed);
    b2 = $random(seed);
    // wait a bit time before enabling
    repeat (20) @(negedge clk);
    en_all = 1'b1;
    rx_enable = 1'b1;
    wait_got(1);
    `CHK(rx_holding_reg, exp_rx(base, 0), "first char")
    `CHK(rx_full_irq, 1'b1, "full irq")
    `CHK(rises, 8, "pulse count")
    `CHK(sck_o, 1'b1, "idle clock")
    `CHK({sck_oe, dma_rx_req, dma_tx_req, tx_empty_irq}, 4'hc, "receive-only requests")
    $display("Test internal receive done");
    tx_enable = 1'b1;
    repeat (2) @(negedge clk);
    `CHK({tx_empty_irq, dma_tx_req}, 2'h3, "empty request")
    @(negedge clk) parity_err_set = 1'b1;
    framing_err_set = 1'b1;
    @(negedge clk) parity_err_set = 1'b0;
    framing_err_set = 1'b0;
    send_sw(b1);
    repeat (64) @(negedge clk);
    `CHK(tx_empty_flag, 1'b0, "start while error")
    `CHK(got, 1, "frame while error")
    `CHK(rx_error_irq, 1'b1, "error irq")
    clr(6'h39);
    `CHK({parity_flag, framing_flag}, 2'h0, "error clear")
    wait_got(2);
    `CHK(peer_u.rx_log[1], b1, "sent char")
    `CHK(overrun_flag, 1'b1, "overrun")
    `CHK(rx_holding_reg, exp_rx(base, 0), "holding kept")
    `CHK(tx_done_irq, 1'b1, "end irq")
    op(5'h02, 8'h00, 6'h3f);
    `CHK(tx_empty_flag, 1'b0, "start while overrun")
    $display("Test error block and overrun done");
    @(negedge clk) tx_enable = 1'b0;
    rx_enable = 1'b0;
    en_all = 1'b0;
    @(negedge clk);
    `CHK(tx_empty_flag, 1'b1, "tx disable")
    `CHK({rx_full_flag, overrun_flag}, 2'h3, "rx disable")
    clr(6'h37);
    op(5'h01, 8'h00, 6'h3f);
    `CHK({rx_full_flag, overrun_flag}, 2'h0, "dma read clear")
    clk_src_sel_hi = 1'b1;
    repeat (20) @(negedge clk);
    en_all = 1'b1;
    tx_enable = 1'b1;
    rx_enable = 1'b1;
    op(5'h02, b2, 6'h3f);
    repeat (3) @(negedge clk);
    `CHK(tx_empty_flag, 1'b1, "shifter load")
    // next char queued before bit 7
    op(5'h02, 8'h80, 6'h3f);
    `CHK(tx_empty_flag, 1'b0, "dma write clear")
    @(negedge clk) ext_go = 1'b1;
    @(negedge clk) ext_go = 1'b0;
    wait_got(4);
    `CHK(peer_u.rx_log[2], b2, "external char")
    `CHK(peer_u.rx_log[3], 8'h80, "chained char")
    `CHK(rx_holding_reg, exp_rx(base, 2), "external receive")
    `CHK(overrun_flag, 1'b1, "external overrun")
    `CHK(tx_done_flag, 1'b1, "transmit end")
    `CHK(rises, 32, "total pulses")
    `CHK({sck_oe, txd_oe, dma_tx_req}, 3'h3, "external pins")
    $display("Test external chain done");
    end_sim;
  end
endmodule // ssx_sync_serial_test
